// *** logic/nosi_pkg.sv ***
`default_nettype none
package nosi_pkg;
  // APB register byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_LAMPS = 8'h10;
  // Control register fields.
  localparam int CTRL_IP_DONE = 0;
  localparam int CTRL_ONLINE = 1;
  localparam int CTRL_SOFT_CLR = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  // Interrupt event bit positions.
  localparam int EV_DIAG_DONE = 0;
  localparam int EV_FATAL = 1;
  localparam int EV_NET_FAULT = 2;
  localparam int EV_LINK_CHG = 3;
  localparam int EV_W = 4;
  localparam logic [3:0] EV_ZERO = 4'h0;
  // Timing.
  localparam int CLK_HZ = 100_000_000;
  localparam int DIAG_MSEC = 2000;
  localparam int DIAG_CYC = CLK_HZ / 1000 * DIAG_MSEC;
  localparam int BLINK_MSEC = 500;
  localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_MSEC / 2;
  localparam int PORTS = 2;
  // Lamp codes.
  typedef enum logic [1:0] {NOSI_OFF, NOSI_GREEN, NOSI_RED} nosi_color_t;
  typedef struct packed {
    nosi_color_t color;
    logic flash;
  } nosi_lamp_t;
  localparam nosi_lamp_t LAMP_DARK = '{NOSI_OFF, 1'b0};
  // Fault inputs grouped together.
  typedef struct packed {
    logic fatal;
    logic nonfatal;
    logic dup_ip;
    logic bad_ip;
    logic timeout;
  } nosi_fault_t;
endpackage : nosi_pkg
`default_nettype wire

// *** logic/nosi_indicators.sv ***
// Added by the designer: the APB register port and the address map.
`default_nettype none
module nosi_indicators #(
  parameter int DIAG_CYCLES = nosi_pkg::DIAG_CYC,
  parameter int BLINK_HALF = nosi_pkg::BLINK_HALF_CYC,
  parameter int NPORT = nosi_pkg::PORTS,
  parameter int SW_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire nosi_pkg::nosi_fault_t fault_in,
  input wire logic conn_established,
  input wire logic ctrl_conn_active,
  input wire logic [NPORT-1:0] port_link_up,
  input wire logic [NPORT-1:0] port_speed_100,
  input wire logic [NPORT-1:0] port_activity,
  input wire logic [SW_W-1:0] protocol_select_switch,
  output logic [SW_W-1:0] protocol_sel,
  output nosi_pkg::nosi_lamp_t module_health_indicator,
  output nosi_pkg::nosi_lamp_t network_health_indicator,
  output nosi_pkg::nosi_lamp_t [NPORT-1:0] port_speed_indicator,
  output nosi_pkg::nosi_lamp_t [NPORT-1:0] port_link_activity_indicator,
  output logic irq
);
  typedef enum logic [1:0] {NOSI_DIAG_RED, NOSI_DIAG_GREEN, NOSI_RUN}
    nosi_phase_t;
  nosi_phase_t phase_reg;
  logic [31:0] diag_cnt_reg;
  logic [31:0] blink_cnt_reg;
  logic blink_reg;
  logic [2:0] ctrl_reg;
  logic [3:0] irq_stat_reg;
  logic [3:0] irq_mask_reg;
  logic [NPORT-1:0] link_prev_reg;
  logic fatal_prev_reg;
  logic net_fault_prev_reg;
  logic [3:0] ev_next;
  logic wr_en;
  logic net_fault;
  logic [31:0] half_m1;
  logic [31:0] diag_m1;

  // Builds a lamp code.
  function automatic nosi_pkg::nosi_lamp_t lamp(
    input nosi_pkg::nosi_color_t c,
    input logic f
  );
    lamp = '{c, f};
  endfunction : lamp
  // Applies the shared blink phase to a lamp code.
  function automatic nosi_pkg::nosi_lamp_t shown(
    input nosi_pkg::nosi_lamp_t l,
    input logic b
  );
    shown = '{(l.flash && !b) ? nosi_pkg::NOSI_OFF : l.color, l.flash};
  endfunction : shown

  assign half_m1 = 32'(BLINK_HALF - 1);
  assign diag_m1 = 32'(DIAG_CYCLES - 1);
  assign net_fault = fault_in.dup_ip | fault_in.bad_ip | fault_in.timeout;
  assign wr_en = psel & penable & pwrite;

  // One blink prescaler for every flashing lamp; software can clear it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end
    else if (ctrl_reg[nosi_pkg::CTRL_SOFT_CLR])
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= 1'b0;
    end
    else if (blink_cnt_reg >= half_m1)
    begin
      blink_cnt_reg <= 32'h0;
      blink_reg <= ~blink_reg;
    end
    else
    begin
      blink_cnt_reg <= blink_cnt_reg + 32'h1;
    end
  end

  // Power-up diagnostic: first half red, second half green, then run.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_reg <= NOSI_DIAG_RED;
      diag_cnt_reg <= 32'h0;
    end
    else
    begin
      case (phase_reg)
        NOSI_DIAG_RED:
        begin
          diag_cnt_reg <= diag_cnt_reg + 32'h1;
          if (diag_cnt_reg >= (diag_m1 >> 1))
          begin
            phase_reg <= NOSI_DIAG_GREEN;
          end
        end
        NOSI_DIAG_GREEN:
        begin
          diag_cnt_reg <= diag_cnt_reg + 32'h1;
          if (diag_cnt_reg >= diag_m1)
          begin
            phase_reg <= NOSI_RUN;
          end
        end
        default: diag_cnt_reg <= diag_cnt_reg;
      endcase
    end
  end

  // Switch follows the input during the diagnostic and is held once it finishes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      protocol_sel <= '0;
    end
    else if (phase_reg != NOSI_RUN)
    begin
      protocol_sel <= protocol_select_switch;
    end
  end

  // Module health lamp by severity.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      module_health_indicator <= nosi_pkg::LAMP_DARK;
    end
    else if (phase_reg != NOSI_RUN)
    begin
      module_health_indicator <= lamp(phase_reg == NOSI_DIAG_RED ?
        nosi_pkg::NOSI_RED : nosi_pkg::NOSI_GREEN, 1'b0);
    end
    else if (fault_in.fatal)
    begin
      module_health_indicator <= lamp(nosi_pkg::NOSI_RED, 1'b0);
    end
    else if (fault_in.nonfatal)
    begin
      module_health_indicator <= shown(lamp(nosi_pkg::NOSI_RED, 1'b1),
        blink_reg);
    end
    else if (!ctrl_reg[nosi_pkg::CTRL_IP_DONE])
    begin
      module_health_indicator <= shown(lamp(nosi_pkg::NOSI_GREEN, 1'b1),
        blink_reg);
    end
    else
    begin
      module_health_indicator <= lamp(nosi_pkg::NOSI_GREEN, 1'b0);
    end
  end

  // Network health lamp by severity.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      network_health_indicator <= nosi_pkg::LAMP_DARK;
    end
    else if (phase_reg != NOSI_RUN || !ctrl_reg[nosi_pkg::CTRL_ONLINE])
    begin
      network_health_indicator <= nosi_pkg::LAMP_DARK;
    end
    else if (net_fault)
    begin
      network_health_indicator <= lamp(nosi_pkg::NOSI_RED, 1'b0);
    end
    else if (ctrl_conn_active)
    begin
      network_health_indicator <= shown(lamp(nosi_pkg::NOSI_GREEN, 1'b1),
        blink_reg);
    end
    else if (conn_established)
    begin
      network_health_indicator <= lamp(nosi_pkg::NOSI_GREEN, 1'b0);
    end
    else
    begin
      network_health_indicator <= nosi_pkg::LAMP_DARK;
    end
  end

  // Per-port speed and link-activity lamps.
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        port_speed_indicator[p] <= nosi_pkg::LAMP_DARK;
        port_link_activity_indicator[p] <= nosi_pkg::LAMP_DARK;
      end
      else if (phase_reg != NOSI_RUN || !port_link_up[p])
      begin
        port_speed_indicator[p] <= nosi_pkg::LAMP_DARK;
        port_link_activity_indicator[p] <= nosi_pkg::LAMP_DARK;
      end
      else
      begin
        port_speed_indicator[p] <= port_speed_100[p] ?
          lamp(nosi_pkg::NOSI_GREEN, 1'b0) : nosi_pkg::LAMP_DARK;
        port_link_activity_indicator[p] <= shown(
          lamp(nosi_pkg::NOSI_GREEN, port_activity[p]), blink_reg);
      end
    end
  end

  // Event detection for interrupts.
  always_comb
  begin
    ev_next = nosi_pkg::EV_ZERO;
    ev_next[nosi_pkg::EV_DIAG_DONE] = (phase_reg == NOSI_DIAG_GREEN) &&
      (diag_cnt_reg >= diag_m1);
    ev_next[nosi_pkg::EV_FATAL] = fault_in.fatal & ~fatal_prev_reg;
    ev_next[nosi_pkg::EV_NET_FAULT] = net_fault & ~net_fault_prev_reg;
    ev_next[nosi_pkg::EV_LINK_CHG] = |(port_link_up ^ link_prev_reg);
  end

  // Edge history for the event detectors.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_prev_reg <= '0;
      fatal_prev_reg <= 1'b0;
      net_fault_prev_reg <= 1'b0;
    end
    else
    begin
      link_prev_reg <= port_link_up;
      fatal_prev_reg <= fault_in.fatal;
      net_fault_prev_reg <= net_fault;
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_reg <= nosi_pkg::EV_ZERO;
    end
    else if (wr_en && paddr == nosi_pkg::ADDR_IRQ_STAT)
    begin
      irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | ev_next;
    end
    else
    begin
      irq_stat_reg <= irq_stat_reg | ev_next;
    end
  end

  // Control and mask writes.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= nosi_pkg::CTRL_RESET;
      irq_mask_reg <= nosi_pkg::EV_ZERO;
    end
    else if (wr_en && paddr == nosi_pkg::ADDR_CTRL)
    begin
      ctrl_reg <= pwdata[2:0];
    end
    else if (wr_en && paddr == nosi_pkg::ADDR_IRQ_MASK)
    begin
      irq_mask_reg <= pwdata[3:0];
    end
  end

  // Interrupt output, registered.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // APB read and response; zero-wait, unmapped addresses raise pslverr.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        if (paddr == nosi_pkg::ADDR_CTRL)
        begin
          prdata <= {29'h0, ctrl_reg};
        end
        else if (paddr == nosi_pkg::ADDR_STATUS)
        begin
          prdata <= {16'h0, 4'(protocol_sel), 6'h0,
            fault_in.fatal, fault_in.nonfatal, net_fault,
            ctrl_conn_active, phase_reg};
        end
        else if (paddr == nosi_pkg::ADDR_IRQ_STAT)
        begin
          prdata <= {28'h0, irq_stat_reg};
        end
        else if (paddr == nosi_pkg::ADDR_IRQ_MASK)
        begin
          prdata <= {28'h0, irq_mask_reg};
        end
        else if (paddr == nosi_pkg::ADDR_LAMPS)
        begin
          prdata <= {26'h0, module_health_indicator,
            network_health_indicator};
        end
        else
        begin
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      end
    end
  end
endmodule : nosi_indicators
`default_nettype wire

// *** tb/nosi_ind_monitor.sv ***
`default_nettype none
module nosi_ind_monitor #(
  parameter int DIAG_CYCLES = 20,
  parameter int NPORT = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire nosi_pkg::nosi_fault_t fault_in,
  input wire logic [NPORT-1:0] port_link_up,
  input wire logic [NPORT-1:0] port_speed_100,
  input wire nosi_pkg::nosi_lamp_t module_health_indicator,
  input wire nosi_pkg::nosi_lamp_t network_health_indicator,
  input wire nosi_pkg::nosi_lamp_t [NPORT-1:0] port_speed_indicator,
  input wire nosi_pkg::nosi_lamp_t [NPORT-1:0] port_link_activity_indicator
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam nosi_pkg::nosi_lamp_t GRN = '{nosi_pkg::NOSI_GREEN, 1'b0};
  localparam nosi_pkg::nosi_lamp_t RED = '{nosi_pkg::NOSI_RED, 1'b0};
  logic [31:0] up_cnt;
  logic run;
  // Counts cycles since reset and stops once the run phase is surely on.
  assign run = up_cnt > 32'(DIAG_CYCLES + 2);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      up_cnt <= 32'h0;
    else if (!run)
      up_cnt <= up_cnt + 32'h1;
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Bus answers, diagnostic blanking and lamp encodings.
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no pready in access");
  unmapped_err_a: assert property (psel && !penable && paddr > 8'h10
    |=> pready && pslverr) else $error("no error on unmapped");
  diag_dark_a: assert property (
    up_cnt < 32'(DIAG_CYCLES - 1) |-> network_health_indicator ==
    nosi_pkg::LAMP_DARK) else $error("network lamp lit in diagnostic");
  fatal_red_a: assert property (
    (run && fault_in.fatal) [*2] |=> module_health_indicator == RED)
    else $error("fatal not steady red");
  nonfatal_flash_a: assert property (
    (run && !fault_in.fatal && fault_in.nonfatal) [*2]
    |=> module_health_indicator.flash &&
    module_health_indicator.color != nosi_pkg::NOSI_GREEN)
    else $error("nonfatal not flashing red");
  speed_on_a: assert property (
    (run && port_link_up[0] && port_speed_100[0]) [*2]
    |=> port_speed_indicator[0] == GRN) else $error("speed lamp not lit");
  speed_off_a: assert property (
    (run && port_link_up[1] && !port_speed_100[1]) [*2]
    |=> port_speed_indicator[1] == nosi_pkg::LAMP_DARK)
    else $error("speed lamp lit at low rate");
  link_dark_a: assert property (
    (run && !port_link_up[1]) [*2]
    |=> port_link_activity_indicator[1] == nosi_pkg::LAMP_DARK)
    else $error("link lamp lit without link");
  // Main scenarios reached.
  cover property (run && fault_in.fatal);
  cover property (psel && penable && pslverr);
  cover property (port_link_activity_indicator[0].flash);
endmodule : nosi_ind_monitor
bind nosi_indicators nosi_ind_monitor #(.DIAG_CYCLES(DIAG_CYCLES),
  .NPORT(NPORT)) u_mon (.*);
`default_nettype wire

// *** tb/nosi_net_model.sv ***
`default_nettype none
module nosi_net_model (
  input wire logic pclk,
  input wire logic [2:0] mode,
  output logic conn_established,
  output logic ctrl_conn_active,
  output logic [1:0] port_link_up,
  output logic [1:0] port_speed_100,
  output logic [1:0] port_activity,
  output logic tmo
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet network until the bench picks a condition.
  initial {conn_established, ctrl_conn_active, tmo} = 3'h0;
  initial {port_link_up, port_speed_100, port_activity} = 6'h00;
  // Mode 1 slow idle links, 2 fast links with control traffic, 3 timeout.
  always @(posedge pclk)
  begin
    conn_established <= mode != 3'h0;
    port_link_up <= {2{mode != 3'h0}};
    port_speed_100 <= {2{mode >= 3'h2}};
    ctrl_conn_active <= mode >= 3'h2;
    port_activity <= {2{mode >= 3'h2}};
    tmo <= mode == 3'h3;
  end
endmodule : nosi_net_model
`default_nettype wire

// *** tb/test_network_option_status_indicators.sv ***
`default_nettype none
module test_network_option_status_indicators;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DG = 20;
  localparam nosi_pkg::nosi_lamp_t GRN = '{nosi_pkg::NOSI_GREEN, 1'b0};
  localparam nosi_pkg::nosi_lamp_t RED = '{nosi_pkg::NOSI_RED, 1'b0};
  localparam nosi_pkg::nosi_lamp_t DRK = nosi_pkg::LAMP_DARK;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic conn_established, ctrl_conn_active, tmo, fatal, nonfatal, er;
  logic [1:0] port_link_up, port_speed_100, port_activity;
  logic [3:0] protocol_select_switch, protocol_sel;
  logic [2:0] mode, nf;
  nosi_pkg::nosi_fault_t fault_in;
  nosi_pkg::nosi_lamp_t module_health_indicator, network_health_indicator;
  nosi_pkg::nosi_lamp_t [1:0] port_speed_indicator;
  nosi_pkg::nosi_lamp_t [1:0] port_link_activity_indicator;
  wire nosi_pkg::nosi_lamp_t mh = module_health_indicator;
  wire nosi_pkg::nosi_lamp_t nh = network_health_indicator;
  int miscompares, check_count;
  // The controller timeout comes from the network model or from nf[0], the rest from here.
  assign fault_in = '{fatal, nonfatal, nf[2], nf[1], nf[0] | tmo};
  nosi_indicators #(.DIAG_CYCLES(DG), .BLINK_HALF(4)) i_nosi_indicators (.*);
  nosi_net_model i_nosi_net_model (.*);
  // Free-running 100 MHz clock.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      chk(1'b0, "bus hang");
      wrap_up;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Diagnostic sequence, then the interrupt is enabled, seen and cleared.
  task automatic t_diag;
    cyc(3);
    chk(mh.color === nosi_pkg::NOSI_RED && nh === DRK, "diag");
    cyc(DG);
    chk(mh.flash === 1'b1 && mh.color !== nosi_pkg::NOSI_RED, "init");
    chk(irq === 1'b0, "irq masked");
    apb(1'b1, nosi_pkg::ADDR_IRQ_MASK, 32'h0000000F);
    cyc(1);
    chk(irq === 1'b1, "irq unmasked");
    apb(1'b0, nosi_pkg::ADDR_IRQ_STAT, 32'h00000000);
    chk(rd[nosi_pkg::EV_DIAG_DONE] === 1'b1, "irq set");
    apb(1'b1, nosi_pkg::ADDR_IRQ_STAT, 32'h00000001);
    apb(1'b0, nosi_pkg::ADDR_IRQ_STAT, 32'h00000000);
    chk(rd[0] === 1'b0 && irq === 1'b0, "irq clear");
  endtask : t_diag
  // Unmapped access is refused; the switch setting stays frozen in run.
  task automatic t_apb;
    apb(1'b0, 8'h14, 32'h00000000);
    chk(er === 1'b1 && rd === 32'h00000000, "unmapped");
    protocol_select_switch <= 4'h5;
    apb(1'b0, nosi_pkg::ADDR_STATUS, 32'h00000000);
    chk(rd[15:12] === 4'hA && protocol_sel === 4'hA, "switch");
  endtask : t_apb
  task automatic t_module;
    apb(1'b1, nosi_pkg::ADDR_CTRL, 32'h00000003);
    cyc(3);
    chk(mh === GRN, "module normal");
    nonfatal <= 1'b1;
    cyc(4);
    chk(mh.flash === 1'b1 && mh.color !== nosi_pkg::NOSI_GREEN, "nf");
    nonfatal <= 1'b0;
  endtask : t_module
  task automatic t_net;
    int n;
    cyc(3);
    chk(port_link_activity_indicator[0] === DRK, "no link");
    mode <= 3'h1;
    cyc(4);
    chk(port_speed_indicator[1] === DRK, "slow");
    chk(port_link_activity_indicator[1] === GRN, "link idle");
    chk(nh === GRN, "connected");
    mode <= 3'h2;
    cyc(4);
    chk(port_speed_indicator[0] === GRN, "fast");
    chk(port_link_activity_indicator[0].flash === 1'b1, "traffic");
    chk(nh.flash === 1'b1 && nh.color !== nosi_pkg::NOSI_RED, "ctl");
    n = 0;
    repeat (16)
    begin
      @(posedge pclk);
      if (nh.color !== nosi_pkg::NOSI_OFF) n++;
    end
    chk(n == 8, "duty");
    apb(1'b1, nosi_pkg::ADDR_CTRL, 32'h00000007);
    n = 0;
    repeat (8)
    begin
      @(posedge pclk);
      if (nh.color !== nosi_pkg::NOSI_OFF) n++;
    end
    chk(n == 0 && nh.flash === 1'b1, "blink held");
    for (int i = 0; i < 3; i++)
    begin
      nf <= 3'h1 << i;
      cyc(4);
      chk(nh === RED, "net fault");
    end
    nf <= 3'h0;
    apb(1'b1, nosi_pkg::ADDR_CTRL, 32'h00000001);
    cyc(3);
    chk(nh === DRK, "offline");
    apb(1'b1, nosi_pkg::ADDR_CTRL, 32'h00000003);
    mode <= 3'h3;
    cyc(4);
    chk(nh === RED, "timeout");
  endtask : t_net
  task automatic t_fatal;
    fatal <= 1'b1;
    nonfatal <= 1'b1;
    cyc(4);
    chk(mh === RED, "fatal");
    apb(1'b0, nosi_pkg::ADDR_IRQ_STAT, 32'h00000000);
    chk(rd[nosi_pkg::EV_FATAL] === 1'b1, "fatal event");
  endtask : t_fatal
  // Reset for ten cycles, then the scenarios in turn.
  initial
  begin
    {presetn, psel, penable, pwrite, fatal, nonfatal} = 6'h00;
    {paddr, pwdata, mode, nf} = '0;
    protocol_select_switch = 4'hA;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_diag;
    t_apb;
    t_module;
    t_net;
    t_fatal;
    wrap_up;
  end
  // Cuts a hang short.
  initial
  begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    wrap_up;
  end
endmodule : test_network_option_status_indicators
`default_nettype wire
